// file: hdl/omc_pkg.sv
// Purpose: shared constants and types of the operating-mode controller
// Assumes: 10 MHz system clock, one clock domain
// Notes:   long counts are mirrored as top-level parameters for simulation
//
// Functional notes
// - power-on reset always lands in init mode
// - watchdog starts long window at reset release
// - init: regulator on, switches drivers cyclics off
// - init transceivers off unless development mode latched
// - frozen settings keep last normal/init values
// - normal: regulator active, supervision enabled
// - normal accepts watchdog configuration writes
// - normal lets writes set high-side switches
// - normal lets writes set bridge and pump
// - normal lets writes set can and lin
// - cyclic sense: switches, wake inputs, timer/sync
// - cyclic wake paced by either cyclic timer
// - stop puts regulator into low-power, still on
// - stop ignores writes and flags write failure
// - stop still allows normal, reset, refresh, clear
// - stop wake/brake events may raise interrupt
// - stop events never change the mode
// - stop: bridge and pump off, rest frozen
// - development mode reports watchdog failure, no reset
package omc_pkg;

  // clock and times, each time in milliseconds
  localparam int unsigned CLK_HZ         = 10_000_000; // system clock rate
  localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
  localparam int unsigned LW_TIME_MS     = 200;        // long open window
  localparam int unsigned LW_CYCLES      = LW_TIME_MS * CYC_PER_MS;
  localparam int unsigned RD_TIME_MS     = 10;         // reset output delay
  localparam int unsigned RD_CYCLES      = RD_TIME_MS * CYC_PER_MS;
  localparam int unsigned WD_BASE_MS     = 10;         // watchdog period step
  localparam int unsigned WD_BASE_CYCLES = WD_BASE_MS * CYC_PER_MS;
  localparam int          CNT_W          = 24;         // timer counter width

  // operating modes, one-hot
  typedef enum logic [2:0] {
    OMC_INIT   = 3'h1,
    OMC_NORMAL = 3'h2,
    OMC_STOP   = 3'h4
  } omc_mode_e;

  // decoded serial-interface write classes
  typedef enum logic [2:0] {
    OMC_OP_MODE     = 3'h0, // mode field write
    OMC_OP_SOFT_RST = 3'h1, // soft reset
    OMC_OP_WD_REFR  = 3'h2, // watchdog refresh
    OMC_OP_STAT_CLR = 3'h3, // read and clear status
    OMC_OP_CONFIG   = 3'h4  // any configuration write
  } omc_op_e;

  // mode field values
  localparam logic [1:0] REQ_NORMAL = 2'h1;
  localparam logic [1:0] REQ_STOP   = 2'h2;

  // configuration word layout
  localparam int          CFG_W      = 16;
  localparam int          CFG_HS     = 0;  // 4 bits high-side enables
  localparam int          CFG_BD     = 4;
  localparam int          CFG_CP     = 5;
  localparam int          CFG_CAN    = 6;
  localparam int          CFG_LIN    = 7;
  localparam int          CFG_CS_EN  = 8;
  localparam int          CFG_CS_SRC = 9;  // 2 bits: 0 timer a, 1 timer b, 2 sync
  localparam int          CFG_CW_EN  = 11;
  localparam int          CFG_CW_SRC = 12; // 0 timer a, 1 timer b
  localparam int          CFG_WD     = 13; // 2 bits period code
  localparam logic [15:0] CFG_RST    = 16'h0000;

  // interrupt event vector
  localparam int EV_W  = 6;
  localparam int EV_WD = 5; // watchdog failure in development mode

endpackage

// file: hdl/omc_watchdog.sv
// Purpose: watchdog timer with long open window and timeout
// Assumes: enable high only while the reset output is released
// Notes:   expiry reloads the long window so a stuck host is re-reported
`timescale 1ns/10ps
`default_nettype none
module omc_watchdog #(
  parameter int unsigned LW_CYC   = omc_pkg::LW_CYCLES,      // long window
  parameter int unsigned BASE_CYC = omc_pkg::WD_BASE_CYCLES  // period step
) (
  input  wire logic       clock,       // system clock
  input  wire logic       reset,       // async, active high
  input  wire logic       enable,      // reset output released
  input  wire logic       restart,     // soft reset restart pulse
  input  wire logic       refresh,     // refresh pulse
  input  wire logic [1:0] period_code, // frozen period setting
  output logic            fail,        // expiry pulse
  output logic            long_win     // long open window active
);
  logic [omc_pkg::CNT_W-1:0] cnt_q;    // remaining cycles
  logic                      long_q;   // long window flag
  wire  [omc_pkg::CNT_W-1:0] lw_load  = omc_pkg::CNT_W'(LW_CYC - 1);
  wire  [omc_pkg::CNT_W-1:0] per_load =
    omc_pkg::CNT_W'(BASE_CYC * (int'(period_code) + 1) - 1);
  wire                       expired  = enable && !restart && !refresh && cnt_q == '0;

  // held in the long window until released; a refresh opens a normal period
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_q  <= '0;
      long_q <= 1'b1;
    end else if (!enable || restart || expired) begin
      cnt_q  <= lw_load;
      long_q <= 1'b1;
    end else if (refresh) begin
      cnt_q  <= per_load;
      long_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_q - 1'b1;
    end
  end

  assign fail     = expired;
  assign long_win = long_q;
endmodule
`default_nettype wire

// file: hdl/omc_irq.sv
// Purpose: sticky event flags gated by mask onto the interrupt pin
// Assumes: clear is a one-cycle pulse from a status clear write
// Notes:   a new event in the clear cycle survives the clear
`timescale 1ns/10ps
`default_nettype none
module omc_irq (
  input  wire logic                  clock,  // system clock
  input  wire logic                  reset,  // async, active high
  input  wire logic [omc_pkg::EV_W-1:0] events, // event pulses
  input  wire logic [omc_pkg::EV_W-1:0] mask,   // 1 lets a flag through
  input  wire logic                  clear,  // clear all flags
  output logic                       int_n,  // interrupt, active low
  output logic [omc_pkg::EV_W-1:0]   pend    // pending flags
);
  logic [omc_pkg::EV_W-1:0] pend_q;  // sticky flags

  // set wins over clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) pend_q <= '0;
    else       pend_q <= (clear ? '0 : pend_q) | events;
  end

  assign pend  = pend_q;
  assign int_n = ~|(pend_q & mask);

  property p_irq_raise;
    @(posedge clock) disable iff (reset)
    |(events & mask) |=> !int_n;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("masked event did not raise irq");
endmodule
`default_nettype wire

// file: hdl/omc_top.sv
// Purpose: operating-mode controller for init, normal and stop modes
// Assumes: serial writes arrive already decoded as one-cycle commands
// Notes:   subsystem enables are decoded from mode and frozen setting flops
`timescale 1ns/10ps
`default_nettype none
module omc_top #(
  parameter int unsigned LW_CYC   = omc_pkg::LW_CYCLES,      // long window
  parameter int unsigned RD_CYC   = omc_pkg::RD_CYCLES,      // reset delay
  parameter int unsigned BASE_CYC = omc_pkg::WD_BASE_CYCLES  // wd step
) (
  input  wire logic        clock,              // 10 MHz clock
  input  wire logic        reset,              // power-on reset, async high
  input  wire logic        test_pin_n,         // development strap, low = dev
  input  wire logic        cmd_valid,          // decoded write pulse
  input  wire logic [2:0]  cmd_op,             // write class
  input  wire logic [1:0]  cmd_mode,           // mode field
  input  wire logic [15:0] cmd_data,           // configuration word
  input  wire logic [4:0]  wake_events,        // can,lin,wake,park,ov pulses
  input  wire logic [5:0]  irq_mask,           // interrupt mask
  output logic             reset_out_n,        // reset output, active low
  output logic             int_n,              // interrupt output, active low
  output logic [2:0]       mode,               // one-hot mode
  output logic             main_regulator_on,  // regulator enabled
  output logic             main_regulator_lp,  // regulator low-power
  output logic             supervision_en,     // monitors enabled
  output logic [3:0]       high_side_switches, // switch enables
  output logic             bridge_driver_en,   // bridge driver enable
  output logic             charge_pump_en,     // charge pump enable
  output logic             can_en,             // can transceiver on
  output logic             lin_en,             // lin transceiver on
  output logic             cyc_sense_en,       // cyclic sense on
  output logic [1:0]       cyc_sense_src,      // sense pacing source
  output logic             cyc_wake_en,        // cyclic wake on
  output logic             cyc_wake_src,       // wake pacing timer
  output logic             wd_long_window,     // watchdog in long window
  output logic             spi_fail,           // write-failure flag
  output logic             sw_dev_mode         // development mode latched
);
  // state
  omc_pkg::omc_mode_e         mode_q, mode_d;  // operating mode
  logic [omc_pkg::CFG_W-1:0]  cfg_q;           // stored settings
  logic [omc_pkg::CNT_W-1:0]  rd_cnt_q;        // reset delay counter
  logic                       rel_q;           // reset output released
  logic                       rel_prev_q;      // release seen last cycle
  logic                       dev_q;           // development mode latched
  logic                       strap_open_q;    // strap window still open
  logic                       fail_q;          // write-failure flag

  // decoded command strobes
  wire op_mode  = cmd_valid && cmd_op == omc_pkg::OMC_OP_MODE;
  wire op_srst  = cmd_valid && cmd_op == omc_pkg::OMC_OP_SOFT_RST;
  wire op_refr  = cmd_valid && cmd_op == omc_pkg::OMC_OP_WD_REFR;
  wire op_clr   = cmd_valid && cmd_op == omc_pkg::OMC_OP_STAT_CLR;
  wire op_cfg   = cmd_valid && cmd_op == omc_pkg::OMC_OP_CONFIG;
  wire in_init  = mode_q == omc_pkg::OMC_INIT;
  wire in_norm  = mode_q == omc_pkg::OMC_NORMAL;
  wire in_stop  = mode_q == omc_pkg::OMC_STOP;
  wire req_norm = op_mode && cmd_mode == omc_pkg::REQ_NORMAL;
  wire req_stop = op_mode && cmd_mode == omc_pkg::REQ_STOP;

  // a write is accepted unless stop filters it; allowed ones pass in stop
  wire stop_ok  = req_norm || op_srst || op_refr || op_clr;
  wire refused  = in_stop && cmd_valid && !stop_ok;
  wire cfg_wr   = op_cfg && (in_norm || in_init);

  // watchdog failure either resets the host or only interrupts it
  wire wd_fail;
  wire wd_reset = wd_fail && !dev_q;
  wire [omc_pkg::EV_W-1:0] events;
  wire [omc_pkg::CNT_W-1:0] rd_last = omc_pkg::CNT_W'(RD_CYC - 1);

  // stop-mode detections only count while in stop
  assign events = {wd_fail && dev_q, in_stop ? wake_events : 5'h00};

  // next mode: wake events are absent from this equation on purpose
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      omc_pkg::OMC_INIT: begin
        if (req_norm)      mode_d = omc_pkg::OMC_NORMAL;
        else if (req_stop) mode_d = omc_pkg::OMC_STOP;
      end
      omc_pkg::OMC_NORMAL: begin
        if (req_stop)      mode_d = omc_pkg::OMC_STOP;
      end
      omc_pkg::OMC_STOP: begin
        if (req_norm)      mode_d = omc_pkg::OMC_NORMAL;
      end
      default:             mode_d = omc_pkg::OMC_INIT;
    endcase
    if (op_srst || wd_reset) mode_d = omc_pkg::OMC_INIT;
  end

  // mode register; power-on reset lands in init
  always_ff @(posedge clock or posedge reset) begin
    if (reset) mode_q <= omc_pkg::OMC_INIT;
    else       mode_q <= mode_d;
  end

  // settings: written in init or normal, frozen elsewhere
  always_ff @(posedge clock or posedge reset) begin
    if (reset)        cfg_q <= omc_pkg::CFG_RST;
    else if (op_srst) cfg_q <= omc_pkg::CFG_RST;
    else if (cfg_wr)  cfg_q <= cmd_data;
  end

  // reset output: held low for the reset delay, also after a wd reset
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_cnt_q <= '0;
      rel_q    <= 1'b0;
    end else if (wd_reset) begin
      rd_cnt_q <= '0;
      rel_q    <= 1'b0;
    end else if (!rel_q) begin
      rd_cnt_q <= rd_cnt_q + 1'b1;
      rel_q    <= rd_cnt_q == rd_last;
    end
  end

  // release edge history, used to open the strap window
  always_ff @(posedge clock or posedge reset) begin
    if (reset) rel_prev_q <= 1'b0;
    else       rel_prev_q <= rel_q;
  end

  // development strap: first command from the second cycle after power-up release decides it;
  // a later wd reset does not reopen the window, only power-on does
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dev_q        <= 1'b0;
      strap_open_q <= 1'b1;
    end else if (strap_open_q && rel_prev_q && cmd_valid) begin
      dev_q        <= in_init && !test_pin_n;
      strap_open_q <= 1'b0;
    end else if (strap_open_q && !in_init) begin
      strap_open_q <= 1'b0;
    end
  end

  // write-failure flag: set wins over clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset)        fail_q <= 1'b0;
    else if (refused) fail_q <= 1'b1;
    else if (op_clr)  fail_q <= 1'b0;
  end

  // watchdog: runs from release, refresh accepted in every mode
  omc_watchdog #(
    .LW_CYC   (LW_CYC),
    .BASE_CYC (BASE_CYC)
  ) u_wd (
    .clock       (clock),
    .reset       (reset),
    .enable      (rel_q),
    .restart     (op_srst),
    .refresh     (op_refr),
    .period_code (cfg_q[omc_pkg::CFG_WD +: 2]),
    .fail        (wd_fail),
    .long_win    (wd_long_window)
  );

  // interrupt flags, cleared by the status clear write
  omc_irq u_irq (
    .clock  (clock),
    .reset  (reset),
    .events (events),
    .mask   (irq_mask),
    .clear  (op_clr),
    .int_n  (int_n),
    .pend   ()
  );

  // subsystem enables decoded from mode and frozen settings
  wire live = in_norm || in_stop; // modes that use stored settings
  assign main_regulator_on  = 1'b1;
  assign main_regulator_lp  = in_stop;
  assign supervision_en     = in_norm;
  assign high_side_switches = live ? cfg_q[omc_pkg::CFG_HS +: 4] : 4'h0;
  assign bridge_driver_en   = in_norm && cfg_q[omc_pkg::CFG_BD];
  assign charge_pump_en     = in_norm && cfg_q[omc_pkg::CFG_CP];
  assign can_en = in_init ? dev_q : cfg_q[omc_pkg::CFG_CAN];
  assign lin_en = in_init ? dev_q : cfg_q[omc_pkg::CFG_LIN];
  assign cyc_sense_en  = live && cfg_q[omc_pkg::CFG_CS_EN];
  assign cyc_sense_src = cfg_q[omc_pkg::CFG_CS_SRC +: 2];
  assign cyc_wake_en   = live && cfg_q[omc_pkg::CFG_CW_EN];
  assign cyc_wake_src  = cfg_q[omc_pkg::CFG_CW_SRC];
  assign reset_out_n   = rel_q;
  assign mode          = mode_q;
  assign spi_fail      = fail_q;
  assign sw_dev_mode   = dev_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_stop_cfg;
    in_stop && op_cfg;
  endsequence

  // a clean configuration write in normal; outside development mode an expiry in that cycle would move the mode
  sequence s_norm_cfg;
    in_norm && op_cfg && !wd_fail;
  endsequence

  property p_init_start;
    $past(reset) |-> mode_q == omc_pkg::OMC_INIT;
  endproperty
  a_init_start: assert property (p_init_start) else $error("not init after reset");

  property p_wd_long;
    $rose(reset_out_n) |=> wd_long_window ##1 wd_long_window;
  endproperty
  a_wd_long: assert property (p_wd_long) else $error("watchdog not in long window");

  property p_init_off;
    in_init |-> high_side_switches == 4'h0 && !bridge_driver_en && !charge_pump_en
                && !cyc_sense_en && !cyc_wake_en && main_regulator_on;
  endproperty
  a_init_off: assert property (p_init_off) else $error("init outputs wrong");

  property p_init_xcvr;
    in_init |-> can_en == sw_dev_mode && lin_en == sw_dev_mode;
  endproperty
  a_init_xcvr: assert property (p_init_xcvr) else $error("init transceivers wrong");

  property p_frozen;
    s_stop_cfg |=> $stable(cfg_q);
  endproperty
  a_frozen: assert property (p_frozen) else $error("settings changed in stop");

  property p_normal_sup;
    in_norm |-> supervision_en && !main_regulator_lp;
  endproperty
  a_normal_sup: assert property (p_normal_sup) else $error("normal supervision off");

  property p_cfg_apply;
    in_norm && op_cfg |=> high_side_switches == $past(cmd_data[3:0])
                          && bridge_driver_en == $past(cmd_data[4]);
  endproperty
  a_cfg_apply: assert property (p_cfg_apply) else $error("normal config not applied");

  property p_stop_lp;
    in_stop |-> main_regulator_on && main_regulator_lp;
  endproperty
  a_stop_lp: assert property (p_stop_lp) else $error("stop regulator state wrong");

  property p_stop_refuse;
    s_stop_cfg |=> spi_fail;
  endproperty
  a_stop_refuse: assert property (p_stop_refuse) else $error("refused write not flagged");

  property p_stop_exit;
    in_stop && req_norm |=> mode_q == omc_pkg::OMC_NORMAL;
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("stop exit ignored");

  property p_stop_hold;
    in_stop && !cmd_valid && !wd_fail |=> in_stop;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("event changed mode");

  property p_stop_bd;
    in_stop |-> !bridge_driver_en && !charge_pump_en;
  endproperty
  a_stop_bd: assert property (p_stop_bd) else $error("bridge on in stop");

  property p_dev_wd;
    wd_fail && sw_dev_mode && irq_mask[omc_pkg::EV_WD] |=> (reset_out_n && !int_n)[*2];
  endproperty
  a_dev_wd: assert property (p_dev_wd) else $error("dev wd failure handled wrong");

  property p_stop_enter;
    in_norm && req_stop && !wd_fail |=> in_stop;
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop entry late");

  // settings decode straight from the stored word, so they show one cycle later
  property p_cp_apply;
    s_norm_cfg |=> charge_pump_en == $past(cmd_data[omc_pkg::CFG_CP]);
  endproperty
  a_cp_apply: assert property (p_cp_apply) else $error("pump config not applied");

  property p_norm_xcvr;
    s_norm_cfg |=> can_en == $past(cmd_data[omc_pkg::CFG_CAN])
                   && lin_en == $past(cmd_data[omc_pkg::CFG_LIN]);
  endproperty
  a_norm_xcvr: assert property (p_norm_xcvr) else $error("transceiver config not applied");

  property p_cs_apply;
    s_norm_cfg |=> cyc_sense_en == $past(cmd_data[omc_pkg::CFG_CS_EN])
                   && cyc_sense_src == $past(cmd_data[omc_pkg::CFG_CS_SRC +: 2]);
  endproperty
  a_cs_apply: assert property (p_cs_apply) else $error("cyclic sense config not applied");

  property p_cw_apply;
    s_norm_cfg |=> cyc_wake_en == $past(cmd_data[omc_pkg::CFG_CW_EN])
                   && cyc_wake_src == $past(cmd_data[omc_pkg::CFG_CW_SRC]);
  endproperty
  a_cw_apply: assert property (p_cw_apply) else $error("cyclic wake config not applied");

  // outside development mode an expiry must pull the host into reset
  property p_wd_reset;
    wd_fail && !sw_dev_mode |=> !reset_out_n && in_init;
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("wd expiry did not reset host");
endmodule
`default_nettype wire

// file: test/omc_host_model.sv
// Purpose: host controller model that issues decoded serial writes
// Assumes: the bench calls its tasks at a falling clock edge
// Notes:   a host held in reset cannot write, so sends wait for release
`timescale 1ns/10ps
`default_nettype none
module omc_host_model (
  input  wire logic   reset_out_n, // device reset output
  input  wire logic   clock,       // system clock
  output logic        cmd_valid,   // write pulse
  output logic [2:0]  cmd_op,      // write class
  output logic [1:0]  cmd_mode,    // mode field
  output logic [15:0] cmd_data     // configuration word
);
  // idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_op = 3'h7;
    cmd_mode = 2'h0;
    cmd_data = 16'h0000;
  end
  // one write; valid stays up so writes can run back to back
  task automatic send(input logic [2:0] op, input logic [1:0] md, input logic [15:0] d);
    while (reset_out_n !== 1'b1) @(negedge clock);
    cmd_valid = 1'b1; // mode changes are plain writes
    cmd_op = op;
    cmd_mode = md;
    cmd_data = d;
    @(negedge clock);
  endtask
  // idle n cycles (n at least 1); op and data flip so stale values are never trusted
  task automatic idle(input int n);
    cmd_valid = 1'b0;
    cmd_op = ~cmd_op;
    cmd_data = ~cmd_data;
    repeat (n) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// file: test/operating_mode_controller_bench.sv
// Purpose: self-checking bench of the operating-mode controller
// Assumes: shortened long window and reset delay counts
// Notes:   a reference model in plain variables predicts every output
`timescale 1ns/10ps
`default_nettype none
module operating_mode_controller_bench;
  localparam int LW = 200; // shortened long window
  localparam int RD = 20;  // shortened reset delay
  localparam int BS = 50;  // shortened watchdog step
  logic        clock, reset, test_pin_n, cmd_valid;
  logic [2:0]  cmd_op, mode;
  logic [1:0]  cmd_mode, cyc_sense_src;
  logic [15:0] cmd_data, m_cfg;
  logic [4:0]  wake_events;
  logic [5:0]  irq_mask, m_flags;
  logic [3:0]  high_side_switches;
  logic        reset_out_n, int_n, main_regulator_on, main_regulator_lp, supervision_en;
  logic        bridge_driver_en, charge_pump_en, can_en, lin_en, cyc_sense_en, cyc_wake_en;
  logic        cyc_wake_src, wd_long_window, spi_fail, sw_dev_mode;
  logic [2:0]  m_mode;                   // model mode
  logic        m_fail, m_dev, m_lw, first; // model flags
  logic [31:0] seed = 32'hC4149022;      // xorshift state
  int          errors = 0;
  int          num_checks = 0;

  omc_top #(.LW_CYC(LW), .RD_CYC(RD), .BASE_CYC(BS)) dut (
    .clock(clock), .reset(reset), .test_pin_n(test_pin_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_mode(cmd_mode), .cmd_data(cmd_data), .wake_events(wake_events),
    .irq_mask(irq_mask), .reset_out_n(reset_out_n), .int_n(int_n), .mode(mode),
    .main_regulator_on(main_regulator_on), .main_regulator_lp(main_regulator_lp),
    .supervision_en(supervision_en), .high_side_switches(high_side_switches),
    .bridge_driver_en(bridge_driver_en), .charge_pump_en(charge_pump_en), .can_en(can_en),
    .lin_en(lin_en), .cyc_sense_en(cyc_sense_en), .cyc_sense_src(cyc_sense_src),
    .cyc_wake_en(cyc_wake_en), .cyc_wake_src(cyc_wake_src),
    .wd_long_window(wd_long_window), .spi_fail(spi_fail), .sw_dev_mode(sw_dev_mode));

  omc_host_model host (.reset_out_n(reset_out_n), .clock(clock), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_mode(cmd_mode), .cmd_data(cmd_data));

  // xorshift source, fixed start value
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // one comparison; four-state equality so an unknown never matches a known value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // compare every output with the model, the pacing sources outside init only
  task automatic check_all();
    logic ini;
    ini = (m_mode == 3'h1);
    chk(mode, m_mode);
    chk({main_regulator_on, main_regulator_lp}, {1'b1, m_mode == 3'h4});
    chk(supervision_en, m_mode == 3'h2);
    chk(high_side_switches, ini ? 4'h0 : m_cfg[3:0]);
    chk({bridge_driver_en, charge_pump_en}, (m_mode == 3'h2) ? {m_cfg[4], m_cfg[5]} : 2'h0);
    chk({can_en, lin_en}, ini ? {m_dev, m_dev} : {m_cfg[6], m_cfg[7]});
    chk({cyc_sense_en, cyc_wake_en}, ini ? 2'h0 : {m_cfg[8], m_cfg[11]});
    if (!ini) chk({cyc_sense_src, cyc_wake_src}, {m_cfg[10:9], m_cfg[12]});
    chk({spi_fail, sw_dev_mode, wd_long_window}, {m_fail, m_dev, m_lw});
    chk({reset_out_n, int_n}, {1'b1, ~|(m_flags & irq_mask)});
  endtask

  // one write through the host, then the model steps and is compared
  task automatic cmd(input logic [2:0] op, input logic [1:0] md, input logic [15:0] d);
    host.send(op, md, d);
    if (first && m_mode == 3'h1) m_dev = ~test_pin_n;
    first = 1'b0;
    if (m_mode == 3'h4 && (op == 3'h4 || (op == 3'h0 && md != 2'h1))) m_fail = 1'b1;
    else if (op == 3'h4) m_cfg = d;
    else if (op == 3'h0 && md == 2'h1) m_mode = 3'h2;
    else if (op == 3'h0 && md == 2'h2) m_mode = 3'h4;
    else if (op == 3'h3) begin
      m_fail = 1'b0;
      m_flags = 6'h00;
    end else if (op == 3'h2) m_lw = 1'b0;
    else if (op == 3'h1) begin
      m_mode = 3'h1;
      m_cfg = 16'h0000;
      m_lw = 1'b1;
    end
    check_all();
  endtask

  // one-cycle event burst; only stop mode records it
  task automatic pulse(input logic [4:0] ev);
    wake_events = ev;
    host.idle(1);
    wake_events = 5'h00;
    if (m_mode == 3'h4) m_flags[4:0] = m_flags[4:0] | ev;
    check_all();
  endtask

  // count cycles until the reset output is released
  task automatic wait_rst(output int n);
    n = 0;
    while (reset_out_n !== 1'b1 && n < 1000) begin
      host.idle(1);
      n++;
    end
  endtask

  // power-on reset with the given development strap
  task automatic power_up(input logic strap_n);
    int n;
    reset = 1'b1;
    test_pin_n = strap_n;
    {m_mode, m_cfg, m_fail, m_flags, m_dev, m_lw, first} = {3'h1, 16'h0, 1'b0, 6'h0, 3'b011};
    repeat (8) @(negedge clock);
    chk({mode, reset_out_n, int_n}, {3'h1, 1'b0, 1'b1});
    reset = 1'b0;
    wait_rst(n);
    chk(16'(n), 16'(RD));
    host.idle(1);
    check_all();
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // a hang counts as a mismatch; the run needs well under 3000 cycles
  initial begin
    #2000000;
    errors++;
    close_out();
  end

  initial begin
    logic [31:0] r;
    int n;
    {reset, test_pin_n, wake_events, irq_mask} = {1'b1, 1'b1, 5'h00, 6'h00};
    power_up(1'b1);
    done("power-on");
    cmd(3'h4, 2'h0, 16'h7FFF); // stored but held off in init
    cmd(3'h0, 2'h1, 16'h0000);
    cmd(3'h4, 2'h0, 16'h0400); // sync pacing
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      {test_pin_n, irq_mask} = r[27:21]; // strap already latched
      cmd(3'h2, 2'h0, 16'h0000);
      cmd(3'h4, 2'h0, r[15:0] & 16'h7BFF);
      pulse(r[20:16]); // dropped outside stop
    end
    done("normal");
    cmd(3'h0, 2'h2, 16'h0000); // configured beforehand
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      irq_mask = r[5:0];
      cmd(3'h2, 2'h0, 16'h0000);
      pulse(r[12:8]);
      cmd(3'h4, 2'h0, r[31:16]);
      cmd(3'h0, 2'h2 + 2'(i % 2), 16'h0000);
      if (i % 2 == 1) cmd(3'h3, 2'h0, 16'h0000);
    end
    done("stop");
    cmd(3'h0, 2'h1, 16'h0000);
    cmd(3'h3, 2'h0, 16'h0000);
    cmd(3'h1, 2'h0, 16'h0000);
    n = 0;
    while (reset_out_n === 1'b1 && n < LW + 50) begin
      host.idle(1);
      n++;
    end
    chk(n >= LW - 5 && n <= LW + 5, 1'b1);
    wait_rst(n);
    chk(16'(n), 16'(RD));
    host.idle(1);
    check_all();
    done("watchdog");
    power_up(1'b0);
    cmd(3'h3, 2'h0, 16'h0000);
    irq_mask = 6'h20;
    n = 0;
    while (int_n === 1'b1 && reset_out_n === 1'b1 && n < LW + 50) begin
      host.idle(1);
      n++;
    end
    m_flags[5] = 1'b1;
    check_all();
    cmd(3'h0, 2'h1, 16'h0000);
    host.idle(1);
    done("development");
    close_out();
  end
endmodule
`default_nettype wire
